// ===== inc/snand_cfg.svh
// Constants of the serial NAND front end: array geometry and link counts
`ifndef SNAND_CFG_SVH
`define SNAND_CFG_SVH
`define SNAND_COL_W        12
`define SNAND_COL_LAST     12'h87F
`define SNAND_MAIN_BYTES   12'h800
`define SNAND_SPARE_ECC    12'h040
`define SNAND_SPARE_ALL    12'h080
`define SNAND_ROW_W        18
`define SNAND_PAGE_HI      5
`define SNAND_BLOCK_LO     6
`define SNAND_BLOCK_HI     17
`define SNAND_BYTE_BITS    4'h8
`define SNAND_IDLE_BYTE    8'hFF
`define SNAND_LOCK_RESET   5'h1F
`define SNAND_LANE_PROTECT 2
`define SNAND_LANE_PAUSE   3
// Idle levels of {select, clock, protect, pause, rx toggle, tx ack} after reset
`define SNAND_SYNC_IDLE    6'h2C
`endif

// ===== inc/snand_pkg.sv
// Types shared by the serial NAND front end
package snand_pkg;
	typedef enum logic [1:0] {
		LANE_X1,
		LANE_X2,
		LANE_X4,
		LANE_DTR4
	} lane_mode_e;

	typedef struct packed {
		logic cmp;
		logic protect_invert_bit;
		logic bp2;
		logic bp1;
		logic bp0;
	} lock_bits_s;

	typedef struct packed {
		logic        col_ok;
		logic        prog_ok;
		logic [5:0]  page;
		logic [11:0] block;
	} addr_result_s;
endpackage : snand_pkg

// ===== design/snand_sync.sv
// Two-flop level synchroniser, one stage pair per bit
`timescale 1ns/10ps
module snand_sync #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	// Clock and reset of the receiving domain
	input  wire logic             clk,
	input  wire logic             rst,
	// Level in and synchronised level out
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	initial begin
		if (WIDTH < 1) $error("snand_sync: WIDTH must be at least 1");
	end

	// First stage is read only by the second stage; reset to idle levels so
	// no false edge follows reset
	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= INIT;
			q    <= INIT;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : snand_sync

// ===== design/serial_nand_host_interface.sv
// Serial NAND front end: lane shifter, pause, lock guard and address checks
`timescale 1ns/10ps
`include "snand_cfg.svh"
module serial_nand_host_interface
	import snand_pkg::*;
#(
	parameter int COL_W = `SNAND_COL_W,
	parameter int ROW_W = `SNAND_ROW_W
) (
	// System clock and reset
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// Serial link pins
	input  wire logic               sclk,
	input  wire logic               cs_n,
	input  wire logic [3:0]         io_lane_in,
	output logic      [3:0]         io_lane_out,
	output logic      [3:0]         io_lane_oe,
	// Transfer configuration
	input  wire lane_mode_e         lane_mode,
	input  wire logic               tx_dir,
	input  wire logic               quad_enable_bit,
	input  wire logic               ecc_enable,
	// Received bytes
	output logic      [7:0]         rx_data,
	output logic                    rx_valid,
	// Bytes to send
	input  wire logic [7:0]         tx_data,
	input  wire logic               tx_valid,
	output logic                    tx_ready,
	// Block lock bits
	input  wire logic               lock_guard_bit,
	input  wire logic               lock_write,
	input  wire lock_bits_s         lock_write_data,
	output lock_bits_s              lock_bits,
	output logic                    lock_refused,
	// Address checks
	input  wire logic               addr_check,
	input  wire logic [COL_W-1:0]   column_address,
	input  wire logic [ROW_W-1:0]   row_address,
	output addr_result_s            addr_result,
	// Link state
	output logic                    pause_active,
	output logic                    link_selected
);
	initial begin
		if (COL_W != `SNAND_COL_W) $error("column address width is fixed");
		if (ROW_W != `SNAND_ROW_W) $error("row address width is fixed");
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Bits moved per edge for a lane mode
	function automatic logic [3:0] lane_step(input lane_mode_e m);
		unique case (m)
			LANE_X1:   lane_step = 4'h1;
			LANE_X2:   lane_step = 4'h2;
			LANE_X4,
			LANE_DTR4: lane_step = 4'h4;
		endcase
	endfunction : lane_step

	// Shift a byte left by the lane count, filling from the lanes
	function automatic logic [7:0] shift_in(input logic [7:0] b, input logic [3:0] l,
	                                         input lane_mode_e m);
		unique case (m)
			LANE_X1:   shift_in = {b[6:0], l[0]};
			LANE_X2:   shift_in = {b[5:0], l[1:0]};
			LANE_X4,
			LANE_DTR4: shift_in = {b[3:0], l[3:0]};
		endcase
	endfunction : shift_in

	// Lane values for the top bits of a byte; single lane sends on lane 1
	function automatic logic [3:0] lanes_out(input logic [7:0] b, input lane_mode_e m);
		unique case (m)
			LANE_X1:   lanes_out = {2'h0, b[7], 1'h0};
			LANE_X2:   lanes_out = {2'h0, b[7:6]};
			LANE_X4,
			LANE_DTR4: lanes_out = b[7:4];
		endcase
	endfunction : lanes_out

	// Lanes driven by the device for a mode
	function automatic logic [3:0] lanes_used(input lane_mode_e m);
		unique case (m)
			LANE_X1:   lanes_used = 4'h2;
			LANE_X2:   lanes_used = 4'h3;
			LANE_X4,
			LANE_DTR4: lanes_used = 4'hF;
		endcase
	endfunction : lanes_used

	// ------------------------------------------------------------
	// Link domain (serial clock, reset while deselected)
	// ------------------------------------------------------------
	logic       link_rst;
	logic [1:0] pause_l;
	logic [1:0] tx_tog_l;
	logic [7:0] rx_shift;
	logic [3:0] rx_count;
	logic [7:0] rx_hold;
	logic       rx_tog;
	logic [7:0] tx_cur;
	logic [3:0] tx_count;
	logic [7:0] tx_pend;
	logic       tx_have;
	logic       tx_seen;
	logic       tx_ack;
	logic [3:0] dtr_low;
	logic [3:0] neg_out;
	logic       link_paused;
	logic       tx_tog;
	logic [7:0] tx_word;

	assign link_rst    = cs_n;
	assign link_paused = pause_l[1];

	// Pause level into the link clock; its edges only come while selected
	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst) pause_l <= 2'h0;
		else pause_l <= {pause_l[0], pause_active};
	end

	// Receive: capture on the rising edge, ignored while paused
	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst) begin
			rx_shift <= 8'h00;
			rx_count <= 4'h0;
			rx_hold  <= 8'h00;
			rx_tog   <= 1'b0;
		end else if (!link_paused && !tx_dir) begin
			rx_shift <= shift_in(rx_shift, io_lane_in, lane_mode);
			if (rx_count + lane_step(lane_mode) >= `SNAND_BYTE_BITS) begin
				rx_count <= 4'h0;
				rx_hold  <= shift_in(rx_shift, io_lane_in, lane_mode);
				rx_tog   <= ~rx_tog;
			end else begin
				rx_count <= rx_count + lane_step(lane_mode);
			end
		end
	end

	// Transmit toggle seen on the falling edge before the byte is loaded
	always_ff @(negedge sclk or posedge link_rst) begin
		if (link_rst) tx_tog_l <= 2'h0;
		else tx_tog_l <= {tx_tog_l[0], tx_tog};
	end

	// Transmit: shift out on the falling edge, byte taken from the pending slot
	always_ff @(negedge sclk or posedge link_rst) begin
		if (link_rst) begin
			tx_cur   <= `SNAND_IDLE_BYTE;
			tx_count <= 4'h0;
			tx_pend  <= `SNAND_IDLE_BYTE;
			tx_have  <= 1'b0;
			tx_seen  <= 1'b0;
			tx_ack   <= 1'b0;
			neg_out  <= 4'h0;
		end else if (!link_paused && tx_dir) begin
			if (tx_tog_l[1] != tx_seen) begin
				tx_seen <= tx_tog_l[1];
				tx_pend <= tx_word;                      // Stable while unacknowledged
				tx_have <= 1'b1;
			end
			if (tx_count == 4'h0) begin
				tx_cur   <= tx_have ? tx_pend : `SNAND_IDLE_BYTE;
				neg_out  <= lanes_out(tx_have ? tx_pend : `SNAND_IDLE_BYTE, lane_mode);
				// Double rate finishes a whole byte on every falling edge
				tx_count <= (lane_mode == LANE_DTR4) ? 4'h0 : lane_step(lane_mode);
				if (tx_have) begin
					tx_have <= 1'b0;
					tx_ack  <= ~tx_ack;
				end
			end else begin
				tx_cur   <= tx_cur << lane_step(lane_mode);
				neg_out  <= lanes_out(tx_cur << lane_step(lane_mode), lane_mode);
				tx_count <= (tx_count + lane_step(lane_mode) >= `SNAND_BYTE_BITS) ?
				            4'h0 : tx_count + lane_step(lane_mode);
			end
		end
	end

	// Double rate: low nibble of the current byte follows on the rising edge
	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst) dtr_low <= 4'h0;
		else if (!link_paused) dtr_low <= tx_cur[3:0];
	end

	// Output mux is the one place where pins do not leave a flop directly
	assign io_lane_out = (lane_mode == LANE_DTR4 && sclk) ? dtr_low : neg_out;

	// ------------------------------------------------------------
	// System domain: pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pin_s;
	logic       cs_s;
	logic       sclk_s;
	logic       protect_s;
	logic       hold_s;
	logic       hold_d;
	logic       rx_tog_s;
	logic       tx_ack_s;

	snand_sync #(.WIDTH(6), .INIT(`SNAND_SYNC_IDLE)) u_sync (
		.clk (clk),
		.rst (sys_rst),
		.d   ({cs_n, sclk, io_lane_in[`SNAND_LANE_PROTECT], io_lane_in[`SNAND_LANE_PAUSE],
		       rx_tog, tx_ack}),
		.q   ({cs_s, sclk_s, protect_s, hold_s, rx_tog_s, tx_ack_s})
	);
	assign pin_s = {cs_s, sclk_s, protect_s, hold_s};

	// ------------------------------------------------------------
	// Pause tracking
	// ------------------------------------------------------------
	logic enter_pend;
	logic exit_pend;

	// Edges of the pause pin wait for a low clock; select high clears all
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hold_d       <= 1'b1;
			enter_pend   <= 1'b0;
			exit_pend    <= 1'b0;
			pause_active <= 1'b0;
		end else begin
			hold_d <= hold_s;
			if (cs_s || quad_enable_bit) begin
				enter_pend   <= 1'b0;
				exit_pend    <= 1'b0;
				pause_active <= 1'b0;
			end else if (!sclk_s) begin
				if ((hold_d && !hold_s) || enter_pend) pause_active <= !hold_s;
				else if ((!hold_d && hold_s) || exit_pend) pause_active <= 1'b0;
				enter_pend <= 1'b0;
				exit_pend  <= 1'b0;
			end else begin
				if (hold_d && !hold_s) enter_pend <= 1'b1;      // Deferred entry
				if (!hold_d && hold_s) exit_pend  <= 1'b1;      // Deferred exit
			end
		end
	end

	// Drive enables: only while selected, sending and not paused
	always_ff @(posedge clk) begin
		if (sys_rst) io_lane_oe <= 4'h0;
		else if (cs_s || pause_active || !tx_dir) io_lane_oe <= 4'h0;
		else io_lane_oe <= lanes_used(lane_mode);
	end

	// Selected flag for the user side; idle when deselected
	always_ff @(posedge clk) begin
		if (sys_rst) link_selected <= 1'b0;
		else link_selected <= !cs_s;
	end

	// ------------------------------------------------------------
	// Byte handoff between domains
	// ------------------------------------------------------------
	logic       rx_seen;

	// Received byte pulse; the held byte is stable until the next toggle
	always_ff @(posedge clk) begin
		if (sys_rst || cs_s) begin
			rx_seen  <= 1'b0;
			rx_valid <= 1'b0;
			rx_data  <= 8'h00;
		end else begin
			rx_valid <= rx_tog_s != rx_seen;
			rx_seen  <= rx_tog_s;
			if (rx_tog_s != rx_seen) rx_data <= rx_hold;
		end
	end

	// One byte in flight; ready again once the link acknowledges it
	always_ff @(posedge clk) begin
		if (sys_rst || cs_s) begin
			tx_tog   <= 1'b0;
			tx_word  <= `SNAND_IDLE_BYTE;
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= (tx_ack_s == tx_tog) && !(tx_valid && tx_ready);
			if (tx_valid && tx_ready) begin
				tx_word <= tx_data;
				tx_tog  <= ~tx_tog;
			end
		end
	end

	// ------------------------------------------------------------
	// Block lock bits
	// ------------------------------------------------------------
	logic lock_blocked;
	assign lock_blocked = lock_guard_bit && !pin_s[1] && !quad_enable_bit;

	// Writes are dropped while the hardware guard holds
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lock_bits    <= `SNAND_LOCK_RESET;
			lock_refused <= 1'b0;
		end else begin
			lock_refused <= lock_write && lock_blocked;
			if (lock_write && !lock_blocked) lock_bits <= lock_write_data; // Pause never stalls
		end
	end

	// ------------------------------------------------------------
	// Address checks
	// ------------------------------------------------------------
	// Spare area end depends on whether correction keeps the top half
	always_ff @(posedge clk) begin
		if (sys_rst) addr_result <= '0;
		else if (addr_check) begin
			addr_result.col_ok  <= column_address <= `SNAND_COL_LAST;
			addr_result.prog_ok <= column_address < `SNAND_MAIN_BYTES +
			    (ecc_enable ? `SNAND_SPARE_ECC : `SNAND_SPARE_ALL);
			addr_result.page    <= row_address[`SNAND_PAGE_HI:0];
			addr_result.block   <= row_address[`SNAND_BLOCK_HI:`SNAND_BLOCK_LO];
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_pause_qe_clear: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(pause_active) |-> $past(!quad_enable_bit)) else $error("pause with quad enable");
	chk_pause_clock_low: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(pause_active) |-> $past(!sclk_s)) else $error("pause entered with clock high");
	chk_exit_clock_low: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(pause_active) && !$past(cs_s) && !$past(quad_enable_bit) |-> $past(!sclk_s))
		else $error("pause left with clock high");
	chk_pause_deselect: assert property (@(posedge clk) disable iff (sys_rst)
		cs_s |=> !pause_active) else $error("pause survives deselect");
	chk_oe_paused: assert property (@(posedge clk) disable iff (sys_rst)
		pause_active |=> io_lane_oe == 4'h0) else $error("driving while paused");
	chk_lock_refuse: assert property (@(posedge clk) disable iff (sys_rst)
		lock_write && lock_blocked |=> lock_refused && $stable(lock_bits))
		else $error("lock bits changed under guard");
	chk_lock_accept: assert property (@(posedge clk) disable iff (sys_rst)
		lock_write && quad_enable_bit |=> lock_bits == $past(lock_write_data) && !lock_refused)
		else $error("lock write lost with quad enable set");
	chk_col_range: assert property (@(posedge clk) disable iff (sys_rst)
		addr_check |=> addr_result.col_ok == ($past(column_address) <= `SNAND_COL_LAST))
		else $error("column range wrong");
	chk_row_split: assert property (@(posedge clk) disable iff (sys_rst)
		addr_check |=> addr_result.block == $past(row_address[`SNAND_BLOCK_HI:`SNAND_BLOCK_LO]) &&
		               addr_result.page == $past(row_address[`SNAND_PAGE_HI:0]))
		else $error("row split wrong");
	chk_spare_ecc: assert property (@(posedge clk) disable iff (sys_rst)
		addr_check && ecc_enable && column_address >= `SNAND_MAIN_BYTES + `SNAND_SPARE_ECC
		|=> !addr_result.prog_ok)
		else $error("protected spare byte programmable");
	chk_spare_raw: assert property (@(posedge clk) disable iff (sys_rst)
		addr_check && !ecc_enable && column_address <= `SNAND_COL_LAST |=> addr_result.prog_ok)
		else $error("spare byte refused without correction");

	cov_pause: cover property (@(posedge clk) disable iff (sys_rst) $rose(pause_active));
	cov_refuse: cover property (@(posedge clk) disable iff (sys_rst) lock_refused);
	cov_rx_byte: cover property (@(posedge clk) disable iff (sys_rst) rx_valid);
	cov_tx_byte: cover property (@(posedge clk) disable iff (sys_rst) tx_valid && tx_ready);
endmodule : serial_nand_host_interface

// ===== tb/snand_host_model.sv
// Host controller model: serial clock, select and the four lane pins
`timescale 1ns/10ps
module snand_host_model (
	// Pins toward the device
	output logic            sclk,
	output logic            cs_n,
	output logic [3:0]      drv,
	output logic [3:0]      drv_en,
	// Resolved lane levels
	input  wire logic [3:0] lanes
);
	logic cpol;

	// Select high, clock parked, protect and pause pins held high
	initial begin
		cpol = 1'b0;
		sclk = 1'b0;
		cs_n = 1'b1;
		drv = 4'hF;
		drv_en = 4'hD;
	end

	// Clock parked at the idle level of the chosen mode before select falls
	task select(input logic mode);
		cpol = mode;
		sclk = mode;
		#15 cs_n = 1'b0;
		#15;
	endtask : select

	// Clock parked again before select rises
	task deselect;
		sclk = cpol;
		#15 cs_n = 1'b1;
		drv[2:0] = 3'h7;
		drv_en = 4'hD;
		#15;
	endtask : deselect

	task pin(input int i, input logic v);
		drv[i] = v;
	endtask : pin

	task sck(input logic v);
		sclk = v;
	endtask : sck

	// One byte MSB first over w lanes; data moves while the clock is low, so the
	// device has half a period of setup before it captures
	task shift(input int w, input logic rx, input logic [7:0] din, output logic [7:0] dout);
		logic [3:0] m;
		m = 4'((1 << w) - 1);
		drv_en = rx ? (4'hC | m) : (w == 1 ? 4'hD : (4'hC & ~m));
		dout = 8'h00;
		for (int i = 0; i < 8 / w; i++) begin
			sclk = 1'b0;
			drv = (drv & ~m) | (4'(din >> (8 - w * (i + 1))) & m);
			#15 sclk = 1'b1;
			dout = (w == 1) ? {dout[6:0], lanes[1]} : 8'((dout << w) | (lanes & m));
			#15;
		end
		sclk = cpol;
	endtask : shift

	// Double rate read on four lanes: high nibble after the fall, low after the rise
	task dtr_read(output logic [7:0] dout);
		drv_en = 4'h0;
		sclk = 1'b0;
		#7 dout[7:4] = lanes;
		#8 sclk = 1'b1;
		#7 dout[3:0] = lanes;
		#8;
	endtask : dtr_read
endmodule : snand_host_model

// ===== tb/tb_top.sv
// Self-checking bench for the serial NAND front end
`timescale 1ns/10ps
`include "snand_cfg.svh"
module tb_top;
	import snand_pkg::*;
	logic         clk, sys_rst, sclk, cs_n, tx_dir, quad_enable_bit, ecc_enable, flt;
	logic [3:0]   io_lane_in, io_lane_out, io_lane_oe, drv, drv_en;
	lane_mode_e   lane_mode;
	logic [7:0]   rx_data, tx_data;
	logic         rx_valid, tx_valid, tx_ready, lock_guard_bit, lock_write, lock_refused;
	lock_bits_s   lock_write_data, lock_bits, mlock;
	logic         addr_check, pause_active, link_selected, rw, ec;
	logic [11:0]  column_address;
	logic [17:0]  row_address;
	addr_result_s addr_result;
	int           fails, comparisons, cyc;
	logic [7:0]   rxq[$];
	logic [11:0]  cols[8] = '{12'h87F, 12'h83F, 12'h880, 12'h840, 12'h000, 12'h7FF, 12'h800, 12'hFFF};
	logic [3:0]   oes[3] = '{4'h2, 4'h3, 4'hF};

	snand_host_model host (.sclk, .cs_n, .drv, .drv_en, .lanes(io_lane_in));
	serial_nand_host_interface dut (.clk, .sys_rst, .sclk, .cs_n, .io_lane_in, .io_lane_out,
		.io_lane_oe, .lane_mode, .tx_dir, .quad_enable_bit, .ecc_enable, .rx_data, .rx_valid,
		.tx_data, .tx_valid, .tx_ready, .lock_guard_bit, .lock_write, .lock_write_data,
		.lock_bits, .lock_refused, .addr_check, .column_address, .row_address, .addr_result,
		.pause_active, .link_selected);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Undriven lanes wander so a stale level never passes for data
	always @(posedge clk) flt <= ~flt;
	assign io_lane_in = (io_lane_oe & io_lane_out) | (~io_lane_oe & drv_en & drv)
		| (~io_lane_oe & ~drv_en & {4{flt}});

	// Cycle ceiling well above the thousand or so cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			$display("unexpected at %0t: run did not finish", $time);
			end_of_test();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk

	task end_of_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test

	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	// One-cycle strobe; the result is registered at the edge that takes it
	task strobe(input logic lk);
		lock_write = lk;
		addr_check = ~lk;
		step(1);
		lock_write = 1'b0;
		addr_check = 1'b0;
	endtask : strobe

	// Offer one byte and hold it until the edge that takes it
	task offer(input logic [7:0] d);
		int n;
		step(1);
		tx_data = d;
		tx_valid = 1'b1;
		n = 0;
		while (tx_ready !== 1'b1 && n < 50) begin
			step(1);
			n++;
		end
		step(1);
		tx_valid = 1'b0;
		chk(n < 50, 1, "byte taken");
	endtask : offer

	// Received bytes are matched in order against what the host sent
	always @(negedge clk) begin
		if (rx_valid === 1'b1) begin
			if (rxq.size() == 0) chk(1, 0, "extra byte");
			else chk(rx_data, rxq.pop_front(), "rx byte");
		end
	end

	initial begin
		logic [7:0] b, r;
		int hit, w;
		{sys_rst, flt, cyc, fails, comparisons} = {1'b1, 1'b0, 96'h0};
		{tx_dir, quad_enable_bit, ecc_enable, tx_valid, lock_guard_bit} = 5'h00;
		{lock_write, addr_check, tx_data, lock_write_data} = 15'h0000;
		{column_address, row_address} = 30'h0;
		lane_mode = LANE_X1;
		mlock = `SNAND_LOCK_RESET;
		repeat (5) @(posedge clk);
		#1 sys_rst = 1'b0;
		void'($urandom(13));
		step(3);
		chk({lock_bits, link_selected, io_lane_oe}, {mlock, 5'h00}, "after reset");
		// Column and spare boundaries first, then random points
		for (int i = 0; i < 48; i++) begin
			column_address = (i < 8) ? cols[i] : 12'($urandom);
			row_address = 18'($urandom);
			ecc_enable = i[0];
			strobe(1'b0);
			ec = column_address <= `SNAND_COL_LAST;
			chk(addr_result, {ec, ec && column_address < (`SNAND_MAIN_BYTES + (ecc_enable ?
				`SNAND_SPARE_ECC : `SNAND_SPARE_ALL)), row_address[5:0], row_address[17:6]},
				"address");
		end
		// Every mix of guard, protect pin and quad enable, each twice
		for (int i = 0; i < 16; i++) begin
			{lock_guard_bit, quad_enable_bit} = i[1:0];
			host.pin(2, i[2]);
			tx_dir = i[3];                 // Ignored while deselected
			lock_write_data = 5'($urandom);
			step(6);
			rw = lock_guard_bit & ~i[2] & ~quad_enable_bit;
			if (!rw) mlock = lock_write_data;
			strobe(1'b1);
			chk({lock_refused, lock_bits}, {rw, mlock}, "lock write");
		end
		// Reset again in mid-run: lock bits return to their reset value
		sys_rst = 1'b1;
		step(5);
		sys_rst = 1'b0;
		mlock = `SNAND_LOCK_RESET;
		step(3);
		chk({lock_refused, lock_bits, link_selected}, {1'b0, mlock, 1'b0}, "second reset");
		{tx_dir, lock_guard_bit, quad_enable_bit} = 3'b000;
		host.pin(2, 1'b1);
		// Bytes in over one lane in both modes, then two and four lanes
		for (int k = 0; k < 4; k++) begin
			lane_mode = lane_mode_e'(k < 2 ? 0 : k - 1);
			quad_enable_bit = (k == 3);
			w = 1 << (k < 2 ? 0 : k - 1);
			host.select(k[0]);
			repeat (2) begin
				b = 8'($urandom);
				rxq.push_back(b);
				host.shift(w, 1'b1, b, r);
			end
			host.deselect();
			step(10);
			chk(rxq.size(), 0, "bytes delivered");
		end
		host.pin(3, 1'b1);
		quad_enable_bit = 1'b0;
		// One byte out over lane 1; bytes with nothing pending read as all ones
		tx_dir = 1'b1;
		lane_mode = LANE_X1;
		host.select(1'b1);
		offer(8'($urandom) & 8'h7F);
		hit = 0;
		for (int i = 0; i < 6; i++) begin
			host.shift(1, 1'b0, 8'h00, r);
			if (r === tx_data) hit++;
			else chk(r, 8'hFF, "idle byte");
		end
		chk(hit, 1, "sent byte");
		host.deselect();
		// Lanes the device drives per lane count; none once deselected
		quad_enable_bit = 1'b1;
		for (int k = 0; k < 3; k++) begin
			lane_mode = lane_mode_e'(k);
			host.select(1'b0);
			step(4);
			chk({link_selected, io_lane_oe}, {1'b1, oes[k]}, "lane enables");
			host.deselect();
			step(4);
			chk({link_selected, io_lane_oe}, 5'h00, "idle");
		end
		// Double rate read, a byte per clock; quad enable is set before it
		quad_enable_bit = 1'b1;
		lane_mode = LANE_DTR4;
		host.select(1'b1);
		offer(8'($urandom) & 8'h7F);
		hit = 0;
		for (int i = 0; i < 6; i++) begin
			host.dtr_read(r);
			if (r === tx_data) hit++;
			else chk(r, 8'hFF, "double rate idle byte");
		end
		chk(hit, 1, "double rate byte");
		host.deselect();
		// Pause seen with the clock high waits for it to go low, both ways
		quad_enable_bit = 1'b0;
		lane_mode = LANE_X1;
		host.select(1'b1);
		host.pin(3, 1'b0);
		step(8);
		chk({pause_active, io_lane_oe}, 5'h02, "entry deferred");
		host.sck(1'b0);
		step(8);
		chk({pause_active, io_lane_oe}, 5'h10, "paused");
		lock_write_data = 5'($urandom);
		mlock = lock_write_data;
		strobe(1'b1);
		chk(lock_bits, mlock, "lock write while paused");
		host.sck(1'b1);
		host.pin(3, 1'b1);
		step(8);
		chk(pause_active, 1, "exit deferred");
		host.sck(1'b0);
		step(8);
		chk({pause_active, io_lane_oe}, 5'h02, "resumed");
		// Select rising in mid-pause clears it; host releases pause before reselecting
		host.pin(3, 1'b0);
		step(8);
		host.deselect();
		step(8);
		chk(pause_active, 0, "select reset");
		host.pin(3, 1'b1);
		// With quad enable set the pause pin is only a data lane
		quad_enable_bit = 1'b1;
		host.select(1'b0);
		host.pin(3, 1'b0);
		step(8);
		chk({pause_active, io_lane_oe}, 5'h02, "no pause");
		host.deselect();
		host.pin(3, 1'b1);
		step(10);
		end_of_test();
	end
endmodule : tb_top
